// ===== design/pin_glitch_filter.sv
// Pin synchroniser with glitch filter for one serial pin
`timescale 1ns/10ps
module pin_glitch_filter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic level_sync,
  output logic level_filt
);
  logic sync1;
  logic sync2;
  logic sync3;
  logic [2:0] cnt;
  logic next_level_sync;
  logic next_level_filt;
  logic [2:0] next_cnt;

  always_comb begin
    next_level_sync = (sync2 == sync3) ? sync3 : level_sync;
    next_level_filt = level_filt;
    next_cnt = 3'h0;
    // Pulses of up to the glitch time never reach the filtered level
    if (level_sync != level_filt) begin
      if (cnt == port3_pkg::GLITCH_CYCLES) begin
        next_level_filt = level_sync;
      end else begin
        next_cnt = cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      level_sync <= 1'b1;
      level_filt <= 1'b1;
      cnt <= 3'h0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      level_sync <= next_level_sync;
      level_filt <= next_level_filt;
      cnt <= next_cnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_filt_change;
    $changed(level_filt) |-> $past(cnt) == port3_pkg::GLITCH_CYCLES;
  endproperty
  a_filt_change: assert property (p_filt_change)
    else $error("filtered level moved before the glitch time");

  property p_short_pulse;
    (level_sync != level_filt) && (cnt != port3_pkg::GLITCH_CYCLES)
      ##1 (level_sync == level_filt) |-> $stable(level_filt);
  endproperty
  a_short_pulse: assert property (p_short_pulse)
    else $error("one-sample pulse passed the filter");

  c_filt_change: cover property ($changed(level_filt));
endmodule : pin_glitch_filter

// ===== design/port3_pin_control.sv
// Port 3 latch, pin drive and serial pin control
// Function
// - latch one releases pin to pull-up
// - latch zero drives pin low
// - secondary function acts only with latch one
// - PWM outputs override latch on bits three, four
// - secondary functions mapped per pin
// - two-wire mode disables strong serial pull-ups
// - SPI mode gives push-pull serial pins
// - two-wire inputs reject pulses up to 50 ns
// - software drives serial pins directly in master
// - MOSI shares bit three latch and driver
// - read-modify-write reads return the latch
// - bit writes change only the selected latch bit
// - plain reads return sampled pin levels
`timescale 1ns/10ps
module port3_pin_control (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpu_wr_byte,
  input wire logic [7:0] cpu_wr_data,
  input wire logic cpu_wr_bit,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic cpu_bit_val,
  input wire logic cpu_rd,
  input wire logic cpu_rd_latch,
  output logic [7:0] cpu_rd_data,
  output logic [7:0] port3_latch,
  input wire logic [7:0] alt_out,
  input wire logic pwm_pin_config,
  input wire logic pwm0_out,
  input wire logic pwm1_out,
  input wire logic serial_port_select,
  input wire logic spi_mosi_out,
  input wire logic [7:0] p3_pin_in,
  output logic [7:0] p3_pin_out,
  output logic [7:0] p3_pin_oe_n,
  output logic uart_rx_in,
  output logic ext_interrupt_a,
  output logic ext_interrupt_b,
  output logic counter_input_a,
  output logic counter_input_b,
  input wire logic spi_drive_en,
  input wire logic spi_sclk_out,
  input wire logic spi_sdata_out,
  input wire logic i2c_scl_low,
  input wire logic i2c_sda_low,
  input wire logic sw_direct_en,
  input wire logic sw_scl,
  input wire logic sw_sda,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  output logic serial_clock_strong,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_n,
  output logic serial_data_strong,
  output logic spi_sclk_in,
  output logic spi_sdata_in,
  output logic i2c_scl_in,
  output logic i2c_sda_in
);
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] pin_stable;
  logic [7:0] next_pin_stable;
  logic [7:0] alt_eff;
  logic [7:0] level;
  logic [7:0] next_latch;
  logic [7:0] next_rd_data;
  logic next_sclk_out;
  logic next_sclk_oe_n;
  logic next_sclk_strong;
  logic next_sdata_out;
  logic next_sdata_oe_n;
  logic next_sdata_strong;

  // Pin sampling and per-pin drive level
  genvar i;
  generate
    for (i = 0; i < port3_pkg::PORT_W; i++) begin : g_pin
      assign next_pin_stable[i] =
        (sync2[i] == sync3[i]) ? sync3[i] : pin_stable[i];
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sync1[i] <= 1'b1;
          sync2[i] <= 1'b1;
          sync3[i] <= 1'b1;
          pin_stable[i] <= 1'b1;
        end else begin
          sync1[i] <= p3_pin_in[i];
          sync2[i] <= sync1[i];
          sync3[i] <= sync2[i];
          pin_stable[i] <= next_pin_stable[i];
        end
      end
    end
  endgenerate

  always_comb begin
    next_latch = port3_latch;
    if (cpu_wr_byte) begin
      next_latch = cpu_wr_data;
    end else if (cpu_wr_bit) begin
      next_latch[cpu_bit_sel] = cpu_bit_val;
    end
    next_rd_data = cpu_rd_data;
    if (cpu_rd) begin
      next_rd_data = cpu_rd_latch ? port3_latch : pin_stable;
    end
    alt_eff = alt_out;
    if (serial_port_select) begin
      alt_eff[port3_pkg::MOSI_BIT] = spi_mosi_out;
    end
    level = port3_latch & alt_eff;
    if (pwm_pin_config) begin
      level[port3_pkg::PWM1_BIT] = pwm1_out;
      level[port3_pkg::PWM0_BIT] = pwm0_out;
    end
    if (serial_port_select) begin
      next_sclk_out = spi_sclk_out;
      next_sclk_oe_n = ~spi_drive_en;
      next_sclk_strong = spi_drive_en & spi_sclk_out;
      next_sdata_out = spi_sdata_out;
      next_sdata_oe_n = ~spi_drive_en;
      next_sdata_strong = spi_drive_en & spi_sdata_out;
    end else begin
      // Open drain: only low is driven, pull-up stays weak
      next_sclk_out = 1'b0;
      next_sclk_strong = 1'b0;
      next_sdata_out = 1'b0;
      next_sdata_strong = 1'b0;
      if (sw_direct_en) begin
        next_sclk_oe_n = sw_scl;
        next_sdata_oe_n = sw_sda;
      end else begin
        next_sclk_oe_n = ~i2c_scl_low;
        next_sdata_oe_n = ~i2c_sda_low;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port3_latch <= port3_pkg::LATCH_RESET;
      cpu_rd_data <= 8'h00;
      p3_pin_out <= 8'hff;
      p3_pin_oe_n <= 8'hff;
      uart_rx_in <= 1'b1;
      ext_interrupt_a <= 1'b1;
      ext_interrupt_b <= 1'b1;
      counter_input_a <= 1'b1;
      counter_input_b <= 1'b1;
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe_n <= 1'b1;
      serial_clock_strong <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe_n <= 1'b1;
      serial_data_strong <= 1'b0;
    end else begin
      port3_latch <= next_latch;
      cpu_rd_data <= next_rd_data;
      p3_pin_out <= level;
      p3_pin_oe_n <= level;
      uart_rx_in <= pin_stable[port3_pkg::RX_BIT];
      ext_interrupt_a <= pin_stable[port3_pkg::INTA_BIT];
      ext_interrupt_b <= pin_stable[port3_pkg::INTB_BIT];
      counter_input_a <= pin_stable[port3_pkg::CNTA_BIT];
      counter_input_b <= pin_stable[port3_pkg::CNTB_BIT];
      serial_clock_pin_out <= next_sclk_out;
      serial_clock_pin_oe_n <= next_sclk_oe_n;
      serial_clock_strong <= next_sclk_strong;
      serial_data_pin_out <= next_sdata_out;
      serial_data_pin_oe_n <= next_sdata_oe_n;
      serial_data_strong <= next_sdata_strong;
    end
  end

  pin_glitch_filter u_sclk_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(serial_clock_pin_in),
    .level_sync(spi_sclk_in),
    .level_filt(i2c_scl_in)
  );

  pin_glitch_filter u_sdata_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(serial_data_pin_in),
    .level_sync(spi_sdata_in),
    .level_filt(i2c_sda_in)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_latch_reset;
    $fell(sys_rst) |-> port3_latch == port3_pkg::LATCH_RESET;
  endproperty
  a_latch_reset: assert property (p_latch_reset)
    else $error("latch not all ones after reset");

  property p_release;
    port3_latch[0] && alt_out[0] |=> p3_pin_oe_n[0];
  endproperty
  a_release: assert property (p_release)
    else $error("pin with latch one not released");

  property p_drive_low;
    !port3_latch[0] |=> !p3_pin_oe_n[0] && !p3_pin_out[0];
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("pin with latch zero not driven low");

  property p_alt_gate;
    port3_latch[6] |=> p3_pin_oe_n[6] == $past(alt_out[6]);
  endproperty
  a_alt_gate: assert property (p_alt_gate)
    else $error("secondary function not passed with latch one");

  property p_pwm;
    pwm_pin_config |=> p3_pin_oe_n[4] == $past(pwm0_out)
      && p3_pin_oe_n[3] == $past(pwm1_out);
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("PWM output did not override latch");

  property p_map;
    ##2 counter_input_a == $past(pin_stable[4])
      && ext_interrupt_a == $past(pin_stable[2]);
  endproperty
  a_map: assert property (p_map)
    else $error("secondary input taken from wrong pin");

  property p_weak;
    !serial_port_select |=> !serial_clock_strong && !serial_data_strong
      && !serial_clock_pin_out;
  endproperty
  a_weak: assert property (p_weak)
    else $error("strong pull-up on in two-wire mode");

  property p_push_pull;
    serial_port_select && spi_drive_en |=> !serial_data_pin_oe_n
      && serial_data_pin_out == $past(spi_sdata_out);
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("SPI data pin not push-pull");

  property p_direct;
    !serial_port_select && sw_direct_en
      |=> serial_clock_pin_oe_n == $past(sw_scl);
  endproperty
  a_direct: assert property (p_direct)
    else $error("software clock control not on pin");

  property p_mosi;
    serial_port_select && port3_latch[3] && !pwm_pin_config
      |=> p3_pin_oe_n[3] == $past(spi_mosi_out);
  endproperty
  a_mosi: assert property (p_mosi)
    else $error("MOSI not on bit three");

  property p_rd_latch;
    cpu_rd && cpu_rd_latch |=> cpu_rd_data == $past(port3_latch);
  endproperty
  a_rd_latch: assert property (p_rd_latch)
    else $error("modify read did not return latch");

  property p_rd_pin;
    cpu_rd && !cpu_rd_latch |=> cpu_rd_data == $past(pin_stable);
  endproperty
  a_rd_pin: assert property (p_rd_pin)
    else $error("plain read did not return pins");

  property p_bit_write;
    cpu_wr_bit && !cpu_wr_byte |=>
      ((port3_latch ^ $past(port3_latch))
        & ~(8'h01 << $past(cpu_bit_sel))) == 8'h00
      && port3_latch[$past(cpu_bit_sel)] == $past(cpu_bit_val);
  endproperty
  a_bit_write: assert property (p_bit_write)
    else $error("bit write disturbed other latch bits");

  c_bit_write: cover property (cpu_wr_bit && !cpu_wr_byte);
  c_pwm: cover property (pwm_pin_config ##1 pwm0_out);
  c_spi: cover property (serial_port_select && spi_drive_en);
  c_direct: cover property (!serial_port_select && sw_direct_en);
endmodule : port3_pin_control

// ===== design/port3_pkg.sv
// Constants shared by the port 3 pin control block
package port3_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] LATCH_RESET = 8'hff;
  // Pin roles
  localparam int RX_BIT = 0;
  localparam int INTA_BIT = 2;
  localparam int INTB_BIT = 3;
  localparam int CNTA_BIT = 4;
  localparam int CNTB_BIT = 5;
  localparam int PWM1_BIT = 3;
  localparam int PWM0_BIT = 4;
  localparam int MOSI_BIT = 3;
  // Glitch rejection, longest rejected pulse rounds down
  localparam int CLK_PERIOD_NS = 10;
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC_I = GLITCH_NS / CLK_PERIOD_NS;
  localparam logic [2:0] GLITCH_CYCLES =
    3'(GLITCH_CYC_I < 1 ? 1 : GLITCH_CYC_I);
endpackage : port3_pkg

// ===== test/pin_world.sv
// Model of the external parts and pull-ups on the port and serial pins
`timescale 1ns/10ps
module pin_world (
  input wire logic [7:0] p3_pin_out,
  input wire logic [7:0] p3_pin_oe_n,
  input wire logic [7:0] ext_low,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic scl_ext,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic sda_ext,
  output logic [7:0] p3_pin_in,
  output logic scl_pin,
  output logic sda_pin
);
  // Released pins float up, any party may pull low
  assign p3_pin_in = (p3_pin_out | p3_pin_oe_n) & ~ext_low;
  assign scl_pin = (scl_out | scl_oe_n) & ~scl_ext;
  assign sda_pin = (sda_out | sda_oe_n) & ~sda_ext;
endmodule : pin_world

// ===== test/test_port3_pin_control.sv
// Testbench for the port 3 pin control block
`timescale 1ns/10ps
module test_port3_pin_control;
  logic clk, sys_rst, cpu_wr_byte, cpu_wr_bit, cpu_bit_val, cpu_rd;
  logic cpu_rd_latch, pwm_pin_config, pwm0_out, pwm1_out;
  logic serial_port_select, spi_mosi_out, spi_drive_en, spi_sclk_out;
  logic spi_sdata_out, i2c_scl_low, i2c_sda_low, sw_direct_en, sw_scl;
  logic sw_sda, serial_clock_pin_in, serial_clock_pin_out;
  logic serial_clock_pin_oe_n, serial_clock_strong, serial_data_pin_in;
  logic serial_data_pin_out, serial_data_pin_oe_n, serial_data_strong;
  logic spi_sclk_in, spi_sdata_in, i2c_scl_in, i2c_sda_in;
  logic uart_rx_in, ext_interrupt_a, ext_interrupt_b;
  logic counter_input_a, counter_input_b, scl_ext, sda_ext, bad;
  logic [2:0] cpu_bit_sel;
  logic [7:0] cpu_wr_data, cpu_rd_data, port3_latch, alt_out;
  logic [7:0] p3_pin_in, p3_pin_out, p3_pin_oe_n, ext_low;
  int failures, comparisons, n;
  // Row: latch, alt, cfg, pwm0, pwm1, select, mosi, drive level
  logic [28:0] rows [9] = '{
    {8'hff, 8'hff, 5'h00, 8'hff}, {8'h00, 8'hff, 5'h00, 8'h00},
    {8'hf0, 8'h0f, 5'h00, 8'h00}, {8'hff, 8'ha5, 5'h00, 8'ha5},
    {8'h00, 8'hff, 5'h1c, 8'h18}, {8'hff, 8'hff, 5'h14, 8'hef},
    {8'hff, 8'hff, 5'h02, 8'hf7}, {8'h00, 8'hff, 5'h03, 8'h00},
    {8'hf7, 8'hff, 5'h03, 8'hf7}};

  port3_pin_control i_port3_pin_control (.clk, .sys_rst, .cpu_wr_byte,
    .cpu_wr_data, .cpu_wr_bit, .cpu_bit_sel, .cpu_bit_val, .cpu_rd,
    .cpu_rd_latch, .cpu_rd_data, .port3_latch, .alt_out, .pwm_pin_config,
    .pwm0_out, .pwm1_out, .serial_port_select, .spi_mosi_out, .p3_pin_in,
    .p3_pin_out, .p3_pin_oe_n, .uart_rx_in, .ext_interrupt_a,
    .ext_interrupt_b, .counter_input_a, .counter_input_b, .spi_drive_en,
    .spi_sclk_out, .spi_sdata_out, .i2c_scl_low, .i2c_sda_low,
    .sw_direct_en, .sw_scl, .sw_sda, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe_n, .serial_clock_strong,
    .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe_n,
    .serial_data_strong, .spi_sclk_in, .spi_sdata_in, .i2c_scl_in,
    .i2c_sda_in);

  pin_world i_pin_world (.p3_pin_out, .p3_pin_oe_n, .ext_low,
    .scl_out(serial_clock_pin_out), .scl_oe_n(serial_clock_pin_oe_n),
    .scl_ext, .sda_out(serial_data_pin_out),
    .sda_oe_n(serial_data_pin_oe_n), .sda_ext,
    .p3_pin_in, .scl_pin(serial_clock_pin_in),
    .sda_pin(serial_data_pin_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check8(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask : check8

  task automatic check1(input logic got, exp, input string what);
    check8({7'h00, got}, {7'h00, exp}, what);
  endtask : check1

  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic wbyte(input logic [7:0] d);
    cpu_wr_byte = 1'b1;
    cpu_wr_data = d;
    cyc(1);
    cpu_wr_byte = 1'b0;
  endtask : wbyte

  task automatic wbit(input logic [2:0] s, input logic v);
    cpu_wr_bit = 1'b1;
    cpu_bit_sel = s;
    cpu_bit_val = v;
    cyc(1);
    cpu_wr_bit = 1'b0;
  endtask : wbit

  task automatic rd(input logic l);
    cpu_rd = 1'b1;
    cpu_rd_latch = l;
    cyc(1);
    cpu_rd = 1'b0;
    cyc(1);
  endtask : rd

  initial begin
    {cpu_wr_byte, cpu_wr_bit, cpu_bit_val, cpu_rd, cpu_rd_latch} = '0;
    {pwm_pin_config, pwm0_out, pwm1_out, serial_port_select} = '0;
    {spi_mosi_out, spi_drive_en, spi_sclk_out, spi_sdata_out} = '0;
    {i2c_scl_low, i2c_sda_low, sw_direct_en, sw_scl, sw_sda} = '0;
    {scl_ext, sda_ext, cpu_bit_sel, cpu_wr_data, ext_low} = '0;
    alt_out = 8'hff;
    sys_rst = 1'b1;
    cyc(5);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      alt_out = rows[i][20:13];
      {pwm_pin_config, pwm0_out, pwm1_out} = rows[i][12:10];
      {serial_port_select, spi_mosi_out} = rows[i][9:8];
      wbyte(rows[i][28:21]);
      cyc(8);
      check8(p3_pin_oe_n, rows[i][7:0], "drive");
      check8(p3_pin_out, rows[i][7:0], "pin out");
      rd(1'b1);
      check8(cpu_rd_data, rows[i][28:21], "latch read");
      rd(1'b0);
      check8(cpu_rd_data, rows[i][7:0], "pin read");
    end
    $display("test drive table done");
    {pwm_pin_config, serial_port_select} = '0;
    wbyte(8'h5a);
    wbit(3'h0, 1'b1);
    check8(port3_latch, 8'h5b, "bit set");
    cyc(1);
    {cpu_wr_byte, cpu_wr_bit, cpu_wr_data} = {2'b11, 8'ha0};
    cyc(1);
    {cpu_wr_byte, cpu_wr_bit} = 2'b00;
    check8(port3_latch, 8'ha0, "byte wins");
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    check8(port3_latch, 8'hff, "latch reset");
    check8(p3_pin_oe_n, 8'hff, "pins reset");
    $display("test bit write and reset done");
    ext_low = 8'h3d;
    cyc(8);
    check8({3'h0, counter_input_b, counter_input_a, ext_interrupt_b,
      ext_interrupt_a, uart_rx_in}, 8'h00, "inputs low");
    ext_low = 8'h14;
    cyc(8);
    check8({3'h0, counter_input_b, counter_input_a, ext_interrupt_b,
      ext_interrupt_a, uart_rx_in}, 8'h15, "input map");
    ext_low = 8'h00;
    i2c_scl_low = 1'b1;
    cyc(3);
    check8({4'h0, serial_clock_pin_oe_n, serial_clock_strong,
      serial_data_pin_oe_n, serial_data_strong}, 8'h02, "i2c");
    {sw_direct_en, sw_scl, sw_sda} = 3'b110;
    cyc(3);
    check8({4'h0, serial_clock_pin_oe_n, serial_clock_strong,
      serial_data_pin_oe_n, serial_data_strong}, 8'h08, "direct");
    {sw_direct_en, i2c_scl_low, serial_port_select} = 3'b001;
    {spi_drive_en, spi_sclk_out, spi_sdata_out} = 3'b101;
    cyc(3);
    check8({4'h0, serial_clock_pin_oe_n, serial_clock_strong,
      serial_data_pin_oe_n, serial_data_strong}, 8'h01, "spi");
    check8({6'h00, serial_clock_pin_out, serial_data_pin_out}, 8'h01,
      "spi out");
    cyc(5);
    check8({6'h00, spi_sclk_in, spi_sdata_in}, 8'h01, "spi in");
    $display("test serial drive done");
    {serial_port_select, spi_drive_en} = 2'b00;
    cyc(20);
    bad = 1'b0;
    {scl_ext, sda_ext} = 2'b11;
    cyc(5);
    {scl_ext, sda_ext} = 2'b00;
    for (n = 0; n < 15; n++) begin
      bad |= (i2c_scl_in !== 1'b1) | (i2c_sda_in !== 1'b1);
      cyc(1);
    end
    check1(bad, 1'b0, "glitch passed");
    {scl_ext, sda_ext} = 2'b11;
    for (n = 0; n < 20 && {i2c_scl_in, i2c_sda_in} !== 2'b00; n++)
      cyc(1);
    if (n == 20) begin
      failures++;
      stop_test();
    end
    check1(i2c_scl_in, 1'b0, "long low");
    check1(i2c_sda_in, 1'b0, "long low data");
    $display("test filter done");
    stop_test();
  end
endmodule : test_port3_pin_control
